// ===== src/psc_pkg.sv
/*
 * Shared constants for the synthesizer control register bank:
 * register offsets, field positions, reset values, serial frame layout.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package psc_pkg;
    // Register offsets (5-bit serial address space)
    localparam logic [4:0] PSC_ADDR_ID_PTR = 5'h00;
    localparam logic [4:0] PSC_ADDR_POWER = 5'h01;
    localparam logic [4:0] PSC_ADDR_REFDIV = 5'h02;
    localparam logic [4:0] PSC_ADDR_INTDIV = 5'h03;
    localparam logic [4:0] PSC_ADDR_FRACDIV = 5'h04;
    localparam logic [4:0] PSC_ADDR_RSVD5 = 5'h05;
    localparam logic [4:0] PSC_ADDR_SDM = 5'h06;
    localparam logic [4:0] PSC_ADDR_LOCK = 5'h07;
    localparam logic [4:0] PSC_ADDR_ANALOG = 5'h08;
    localparam logic [4:0] PSC_ADDR_GENOUT = 5'h0f;

    // Reset values, 24-bit words
    localparam logic [23:0] PSC_RST_POWER = 24'h000003;
    localparam logic [23:0] PSC_RST_REFDIV = 24'h000001;
    localparam logic [23:0] PSC_RST_INTDIV = 24'h000019;
    localparam logic [23:0] PSC_RST_FRACDIV = 24'h000000;
    localparam logic [23:0] PSC_RST_RSVD5 = 24'h000000;
    localparam logic [23:0] PSC_RST_SDM = 24'h061f0a;
    localparam logic [23:0] PSC_RST_LOCK = 24'h20404c;
    localparam logic [23:0] PSC_RST_ANALOG = 24'h01bfff;
    localparam logic [23:0] PSC_RST_GENOUT = 24'h000001;

    // Field positions
    localparam int PSC_BIT_SOFT_RESET = 5;
    localparam int PSC_BIT_PIN_SELECT = 0;
    localparam int PSC_BIT_REG_ENABLE = 1;
    localparam int PSC_BIT_KEEP_LO = 2;
    localparam int PSC_BIT_ORDER_LO = 2;
    localparam int PSC_BIT_SYNC_LOAD = 4;
    localparam int PSC_BIT_EXACT = 5;
    localparam int PSC_BIT_BYPASS = 7;
    localparam int PSC_BIT_AUTOSEED = 8;
    localparam int PSC_BIT_SDM_ENABLE = 11;
    localparam int PSC_BIT_LOCK_ENABLE = 11;
    localparam int PSC_BIT_SLIP_GUARD = 15;
    localparam int PSC_BIT_TRAINING = 20;
    localparam int PSC_BIT_HIGH_REF = 21;
    localparam int PSC_BIT_OUT_LEVEL = 22;
    localparam int PSC_BIT_TEST_DATA = 5;
    localparam int PSC_BIT_NO_AUTOMUX = 6;

    // General output select codes
    localparam logic [4:0] PSC_GEN_TEST_DATA = 5'h00;
    localparam logic [4:0] PSC_GEN_LOCK = 5'h01;

    // Serial frame: 24 data bits, 5 address bits, 3 spare bits, MSB first
    localparam int PSC_FRAME_BITS = 32;
    localparam int PSC_DATA_BITS = 24;
    localparam int PSC_ADDR_LO = 3;
endpackage

// ===== src/psc_regs.sv
/*
 * Control register bank of a fractional-N synthesizer with its three-wire
 * serial port and shared lock/readback output pin.
 * Assumes: serial clock stands still outside frames; the select line is
 * high between frames; divider, lock and phase inputs are ref_clk-domain
 * pulses or levels from the analog wrapper; the enable pin is asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Shared pin shows lock, serial readback data, or a selected general signal.
// - Address field written at offset zero picks the word read next.
// - Bit five at offset zero soft-resets the registers and control outputs; the serial link, readback word and pin register keep their state.
// - With pin select set, a low enable pin powers the chip down.
// - With pin select clear, the register enable bit alone powers the chip.
// - Six keep-on bits hold their blocks active regardless of chip enable.
// - Reference divider is 14 bits, default one.
// - Integer divider is 19 bits, default 25; host keeps it in range.
// - Fractional divider is 24 bits unsigned, used only in fractional mode.
// - Two-bit field selects modulator order, default third order.
// - Normal loads apply at select rise; synchronous mode waits for internal clock.
// - One bit enables exact frequency mode, off by default.
// - Bypass ignores modulator output; modulator still clocked while enabled.
// - Auto-seed reloads modulator phase on each fractional write.
// - Modulator enable bit gates the sigma-delta core, default on.
// - Window code picks consecutive in-window edges needed to declare lock.
// - Lock detect enable bit turns lock detection on, default off.
// - Cycle-slip guard boosts charge pump while phase error is large.
// - Rising training bit starts lock detect training.
// - High-frequency reference bit puts reference buffer in low gain.
// - Output level bit selects 1.8 V or digital supply level on pin.
// - Select, data and clock lines from host; select frames each access.
module psc_regs #(
    parameter logic [23:0] ID_CODE = 24'h5a5a01, // Arbitrary identification value
    parameter int WIN_W = 17
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic serialClock,
    input wire logic serialPortSelect,
    input wire logic serialInLine,
    input wire logic chipEnablePin,
    input wire logic pfdTick,
    input wire logic dividedVcoEdge,
    input wire logic edgeInWindow,
    input wire logic phaseErrorLarge,
    output logic lockOrReadbackPin,
    output logic pinLevelHigh,
    output logic chipEnabled,
    output logic [5:0] keepOnActive,
    output logic [13:0] referenceDivider,
    output logic [18:0] integerDivider,
    output logic [23:0] fractionalDivider,
    output logic [1:0] sigmaDeltaOrder,
    output logic sigmaDeltaEnable,
    output logic useModulatorOutput,
    output logic seedLoadPulse,
    output logic exactFrequencyMode,
    output logic lockDetected,
    output logic trainingStartPulse,
    output logic cycleSlipBoost,
    output logic refBufferLowGain
);
    import psc_pkg::*;

    // Lock window code to required consecutive in-window edges
    function automatic logic [WIN_W-1:0] windowTarget(input logic [2:0] code);
        case (code)
            3'h0: windowTarget = WIN_W'(5);
            3'h1: windowTarget = WIN_W'(32);
            3'h2: windowTarget = WIN_W'(96);
            3'h3: windowTarget = WIN_W'(256);
            3'h4: windowTarget = WIN_W'(512);
            3'h5: windowTarget = WIN_W'(2048);
            3'h6: windowTarget = WIN_W'(8192);
            default: windowTarget = WIN_W'(65535);
        endcase
    endfunction

    // Link domain: shifter, bit counter, readback shifter
    logic [PSC_FRAME_BITS-1:0] shiftIn_reg;
    logic [5:0] bitCount_reg;
    logic [23:0] readShift_reg;
    logic [23:0] readWord_reg;

    // Select high clears the counter; it is the only reset this domain has
    always_ff @(posedge serialClock or posedge serialPortSelect) begin
        if (serialPortSelect) begin
            bitCount_reg <= 6'h00;
        end else if (bitCount_reg != 6'h3f) begin
            bitCount_reg <= bitCount_reg + 6'h01;
        end
    end

    // Data in MSB first; shifter holds still between frames
    always_ff @(posedge serialClock) begin
        shiftIn_reg <= {shiftIn_reg[PSC_FRAME_BITS-2:0], serialInLine};
    end

    // Readback word is loaded at the first edge; it only changes outside frames
    always_ff @(posedge serialClock) begin
        if (bitCount_reg == 6'h00) begin
            readShift_reg <= readWord_reg;
        end else begin
            readShift_reg <= {readShift_reg[22:0], 1'b0};
        end
    end

    // Crossings into ref_clk: select level, readback bit, enable pin
    logic selMeta_reg, selSync_reg, selPrev_reg;
    logic rdMeta_reg, rdSync_reg;
    logic enMeta_reg, enSync_reg;
    always_ff @(posedge ref_clk) begin
        selMeta_reg <= serialPortSelect;
        selSync_reg <= selMeta_reg;
        selPrev_reg <= selSync_reg;
        rdMeta_reg <= readShift_reg[23];
        rdSync_reg <= rdMeta_reg;
        enMeta_reg <= chipEnablePin;
        enSync_reg <= enMeta_reg;
    end

    // Commit decode; shifter is quasi-static once select has risen
    wire commit = selSync_reg & ~selPrev_reg & ~rst;
    wire [4:0] wrAddr = shiftIn_reg[PSC_ADDR_LO+4:PSC_ADDR_LO];
    wire [23:0] wrData = shiftIn_reg[PSC_FRAME_BITS-1:PSC_FRAME_BITS-PSC_DATA_BITS];
    wire softReset = commit & (wrAddr == PSC_ADDR_ID_PTR) & wrData[PSC_BIT_SOFT_RESET];
    wire clearAll = rst | softReset;
    wire wrPtr = commit & (wrAddr == PSC_ADDR_ID_PTR);
    wire wrInt = commit & (wrAddr == PSC_ADDR_INTDIV);
    wire wrFrac = commit & (wrAddr == PSC_ADDR_FRACDIV);

    // Register storage; bits above each field are stored as zero, offset 5 and analog words are kept as written
    logic [4:0] readPointer_reg;
    logic [23:0] power_reg, refDiv_reg, intDiv_reg, fracDiv_reg, rsvd5_reg;
    logic [23:0] sdm_reg, lock_reg, analog_reg, genOut_reg;
    always_ff @(posedge ref_clk) begin
        if (clearAll) begin
            readPointer_reg <= PSC_ADDR_ID_PTR;
            power_reg <= PSC_RST_POWER;
            refDiv_reg <= PSC_RST_REFDIV;
            intDiv_reg <= PSC_RST_INTDIV;
            fracDiv_reg <= PSC_RST_FRACDIV;
            rsvd5_reg <= PSC_RST_RSVD5;
            sdm_reg <= PSC_RST_SDM;
            lock_reg <= PSC_RST_LOCK;
            analog_reg <= PSC_RST_ANALOG;
            genOut_reg <= PSC_RST_GENOUT;
        end else if (commit) begin
            case (wrAddr)
                PSC_ADDR_ID_PTR: readPointer_reg <= wrData[4:0];
                PSC_ADDR_POWER: power_reg <= {14'h0000, wrData[9:0]};
                PSC_ADDR_REFDIV: refDiv_reg <= {10'h000, wrData[13:0]};
                PSC_ADDR_INTDIV: intDiv_reg <= {5'h00, wrData[18:0]};
                PSC_ADDR_FRACDIV: fracDiv_reg <= wrData;
                PSC_ADDR_RSVD5: rsvd5_reg <= wrData;
                PSC_ADDR_SDM: sdm_reg <= {1'b0, wrData[22:0]};
                PSC_ADDR_LOCK: lock_reg <= {2'h0, wrData[21:0]};
                PSC_ADDR_ANALOG: analog_reg <= wrData;
                PSC_ADDR_GENOUT: genOut_reg <= {18'h00000, wrData[5:0]};
                default: readPointer_reg <= readPointer_reg;
            endcase
        end
    end

    // Readback mux; unmapped addresses read zero
    logic [23:0] readSel;
    always_comb begin
        case (readPointer_reg)
            PSC_ADDR_ID_PTR: readSel = ID_CODE;
            PSC_ADDR_POWER: readSel = power_reg;
            PSC_ADDR_REFDIV: readSel = refDiv_reg;
            PSC_ADDR_INTDIV: readSel = intDiv_reg;
            PSC_ADDR_FRACDIV: readSel = fracDiv_reg;
            PSC_ADDR_RSVD5: readSel = rsvd5_reg;
            PSC_ADDR_SDM: readSel = sdm_reg;
            PSC_ADDR_LOCK: readSel = lock_reg;
            PSC_ADDR_ANALOG: readSel = analog_reg;
            PSC_ADDR_GENOUT: readSel = genOut_reg;
            default: readSel = 24'h000000;
        endcase
    end

    // Word presented to the link; refreshed only outside frames
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            readWord_reg <= ID_CODE;
        end else if (selSync_reg) begin
            readWord_reg <= readSel;
        end
    end

    // Applied divider values; synchronous mode defers to the detector tick
    logic syncMode;
    logic intPending_reg, fracPending_reg;
    assign syncMode = sdm_reg[PSC_BIT_SYNC_LOAD];
    always_ff @(posedge ref_clk) begin
        if (clearAll) begin
            integerDivider <= PSC_RST_INTDIV[18:0];
            fractionalDivider <= PSC_RST_FRACDIV;
            intPending_reg <= 1'b0;
            fracPending_reg <= 1'b0;
        end else begin
            if (wrInt & ~syncMode) begin
                integerDivider <= wrData[18:0];
            end else if (intPending_reg & pfdTick) begin
                integerDivider <= intDiv_reg[18:0];
            end
            if (wrFrac & ~syncMode) begin
                fractionalDivider <= wrData;
            end else if (fracPending_reg & pfdTick) begin
                fractionalDivider <= fracDiv_reg;
            end
            // A new write wins over the tick that would clear pending
            intPending_reg <= (wrInt & syncMode) | (intPending_reg & ~pfdTick);
            fracPending_reg <= (wrFrac & syncMode) | (fracPending_reg & ~pfdTick);
        end
    end

    // Seed reload follows the moment the fractional value is applied
    wire fracApplied = (wrFrac & ~syncMode) | (fracPending_reg & pfdTick);
    wire trainRise = commit & (wrAddr == PSC_ADDR_LOCK) & wrData[PSC_BIT_TRAINING] &
        ~lock_reg[PSC_BIT_TRAINING];

    // Power and mode decode
    wire enableNext = power_reg[PSC_BIT_PIN_SELECT] ? enSync_reg
        : power_reg[PSC_BIT_REG_ENABLE];
    wire [5:0] keepBits = power_reg[PSC_BIT_KEEP_LO+5:PSC_BIT_KEEP_LO];
    wire lockEnable = lock_reg[PSC_BIT_LOCK_ENABLE];
    wire [WIN_W-1:0] target = windowTarget(lock_reg[2:0]);

    // Control outputs and strobes, all registered
    always_ff @(posedge ref_clk) begin
        if (clearAll) begin
            chipEnabled <= 1'b0;
            keepOnActive <= 6'h00;
            referenceDivider <= PSC_RST_REFDIV[13:0];
            sigmaDeltaOrder <= PSC_RST_SDM[PSC_BIT_ORDER_LO+1:PSC_BIT_ORDER_LO];
            sigmaDeltaEnable <= PSC_RST_SDM[PSC_BIT_SDM_ENABLE];
            useModulatorOutput <= ~PSC_RST_SDM[PSC_BIT_BYPASS];
            exactFrequencyMode <= PSC_RST_SDM[PSC_BIT_EXACT];
            refBufferLowGain <= PSC_RST_ANALOG[PSC_BIT_HIGH_REF];
            pinLevelHigh <= PSC_RST_ANALOG[PSC_BIT_OUT_LEVEL];
            seedLoadPulse <= 1'b0;
            trainingStartPulse <= 1'b0;
            cycleSlipBoost <= 1'b0;
        end else begin
            chipEnabled <= enableNext;
            keepOnActive <= keepBits | {6{enableNext}};
            referenceDivider <= refDiv_reg[13:0];
            sigmaDeltaOrder <= sdm_reg[PSC_BIT_ORDER_LO+1:PSC_BIT_ORDER_LO];
            sigmaDeltaEnable <= sdm_reg[PSC_BIT_SDM_ENABLE];
            useModulatorOutput <= ~sdm_reg[PSC_BIT_BYPASS];
            exactFrequencyMode <= sdm_reg[PSC_BIT_EXACT];
            refBufferLowGain <= analog_reg[PSC_BIT_HIGH_REF];
            pinLevelHigh <= analog_reg[PSC_BIT_OUT_LEVEL];
            seedLoadPulse <= fracApplied & sdm_reg[PSC_BIT_AUTOSEED];
            trainingStartPulse <= trainRise;
            cycleSlipBoost <= lock_reg[PSC_BIT_SLIP_GUARD] & phaseErrorLarge;
        end
    end

    // Lock detector: consecutive in-window edges against the window target
    logic [WIN_W-1:0] winCount_reg;
    always_ff @(posedge ref_clk) begin
        if (clearAll | ~lockEnable | trainRise) begin
            winCount_reg <= '0;
            lockDetected <= 1'b0;
        end else if (dividedVcoEdge) begin
            if (~edgeInWindow) begin
                winCount_reg <= '0;
                lockDetected <= 1'b0;
            end else if (winCount_reg + WIN_W'(1) >= target) begin
                winCount_reg <= target;
                lockDetected <= 1'b1;
            end else begin
                winCount_reg <= winCount_reg + WIN_W'(1);
            end
        end
    end

    // Shared pin: readback during a frame, else general output; the stored general output word never keeps the no-automux bit
    wire [4:0] genSel = genOut_reg[4:0];
    wire genValue = (genSel == PSC_GEN_TEST_DATA) ? genOut_reg[PSC_BIT_TEST_DATA]
        : (genSel == PSC_GEN_LOCK) ? lockDetected : 1'b0;
    wire inFrame = ~selSync_reg & ~genOut_reg[PSC_BIT_NO_AUTOMUX];
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lockOrReadbackPin <= 1'b0;
        end else begin
            lockOrReadbackPin <= inFrame ? rdSync_reg : genValue;
        end
    end
endmodule

`default_nettype wire

// ===== tb/psc_host.sv
/* Host model of the three-wire serial port: writes frames, captures readback.
   Assumes the device samples data on serial clock rise and answers MSB first. */
`timescale 1ns/1ps
`default_nettype none
module psc_host (
    output logic serialClock,
    output logic serialPortSelect,
    output logic serialInLine,
    input wire logic readbackPin
);
    logic [23:0] readWord;
    // Idle: clock stands still, frame line high
    initial begin
        serialClock = 1'b0;
        serialPortSelect = 1'b1;
        serialInLine = 1'b0;
    end
    // One 32-bit frame at 125 ns per bit; readback sampled just before the next rise
    task automatic frame(input logic [4:0] a, input logic [23:0] d);
        logic [31:0] w;
        w = {d, a, 3'h0};
        serialPortSelect = 1'b0;
        for (int i = 31; i >= 0; i--) begin
            serialInLine = w[i];
            #5 serialClock = 1'b1;
            #62.5 serialClock = 1'b0;
            #57.5 if (i > 7) readWord[i - 8] = readbackPin;
        end
        serialInLine = ~serialInLine; // Released line carries no stale bit
        serialPortSelect = 1'b1;
        #1000; // Spacing between frames, shifter left untouched
    endtask
endmodule
`default_nettype wire

// ===== tb/psc_regs_sva.sv
/* Checker for the synthesizer register bank, bound into psc_regs.
   Assumes one ref_clk domain; the serial link is seen through its frame line. */
`timescale 1ns/1ps
`default_nettype none
module psc_regs_sva (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic serialPortSelect,
    input wire logic dividedVcoEdge,
    input wire logic edgeInWindow,
    input wire logic phaseErrorLarge,
    input wire logic lockOrReadbackPin,
    input wire logic chipEnabled,
    input wire logic [5:0] keepOnActive,
    input wire logic [13:0] referenceDivider,
    input wire logic [18:0] integerDivider,
    input wire logic [23:0] fractionalDivider,
    input wire logic seedLoadPulse,
    input wire logic lockDetected,
    input wire logic trainingStartPulse,
    input wire logic cycleSlipBoost
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    // Reset defaults, and values that must hold still while a frame shifts in
    a_reset_values: assert property ($fell(rst) |-> referenceDivider == 14'h0001 &&
        integerDivider == 19'h00019 && fractionalDivider == 24'h000000 && !chipEnabled)
        else $error("outputs not at defaults after reset");
    a_frame_holds: assert property (!serialPortSelect && !$past(serialPortSelect) |->
        $stable(integerDivider) && $stable(fractionalDivider)) else $error("divider moved in frame");
    a_seed_single: assert property (seedLoadPulse |=> !seedLoadPulse)
        else $error("seed pulse too long");
    a_train_single: assert property (trainingStartPulse |=> !trainingStartPulse)
        else $error("training pulse too long");
    a_miss_clears: assert property (dividedVcoEdge && !edgeInWindow |-> ##[1:2] !lockDetected)
        else $error("lock kept after window miss");
    a_boost_cause: assert property (cycleSlipBoost |-> $past(phaseErrorLarge))
        else $error("boost without phase error");
    a_boost_drop: assert property (!$past(phaseErrorLarge) |-> !cycleSlipBoost)
        else $error("boost outlived phase error");
    a_keep_follow: assert property (chipEnabled |-> keepOnActive == 6'h3f)
        else $error("block off while chip enabled");
    a_pin_general: assert property (serialPortSelect [*8] |-> lockOrReadbackPin == $past(lockDetected))
        else $error("pin not showing lock between frames");
    // Main scenarios reached
    c_lock: cover property ($rose(lockDetected));
    c_seed: cover property (seedLoadPulse);
    c_boost: cover property (cycleSlipBoost);
endmodule
bind psc_regs psc_regs_sva chk (.*);
`default_nettype wire

// ===== tb/test_pll_synth_control_regs.sv
/* Self-checking bench for the synthesizer register bank.
   Assumes psc_host on the serial port and the constants of psc_pkg. */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin nErrors++; \
    $display("unexpected %s expected %0h seen %0h", nm, exp, got); end end
module test_pll_synth_control_regs;
    import psc_pkg::*;
    localparam logic [23:0] ID = 24'h3c3c07; // Arbitrary identification value
    logic ref_clk, rst, chipEnablePin, pfdTick, dividedVcoEdge, edgeInWindow, phaseErrorLarge;
    logic serialClock, serialPortSelect, serialInLine, lockOrReadbackPin, pinLevelHigh, chipEnabled;
    logic sigmaDeltaEnable, useModulatorOutput, seedLoadPulse, exactFrequencyMode, lockDetected;
    logic trainingStartPulse, cycleSlipBoost, refBufferLowGain;
    logic [5:0] keepOnActive;
    logic [13:0] referenceDivider;
    logic [18:0] integerDivider;
    logic [23:0] fractionalDivider, d, w;
    logic [1:0] sigmaDeltaOrder;
    int nErrors, comparisons, seed, seeds, trains, v;
    int cnt[7] = '{5, 32, 96, 256, 512, 2048, 8192};
    psc_regs #(.ID_CODE(ID)) uut (.*);
    psc_host host (.serialClock(serialClock), .serialPortSelect(serialPortSelect),
        .serialInLine(serialInLine), .readbackPin(lockOrReadbackPin));
    // 50 MHz main clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // Strobe counters
    always @(posedge ref_clk) begin
        if (seedLoadPulse === 1'b1) seeds++;
        if (trainingStartPulse === 1'b1) trains++;
    end
    function automatic logic [23:0] dflt(input int a);
        case (a)
            0: return ID;
            1: return 24'h000003;
            2: return 24'h000001;
            3: return 24'h000019;
            6: return PSC_RST_SDM;
            7: return PSC_RST_LOCK;
            8: return PSC_RST_ANALOG;
            default: return 24'h000000;
        endcase
    endfunction
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // Pointer frame, then a harmless frame that carries the word out
    task automatic rd(input logic [4:0] a, output logic [23:0] r);
        host.frame(PSC_ADDR_ID_PTR, {19'h0, a});
        host.frame(5'h1f, 24'h000000);
        r = host.readWord;
    endtask
    // Divided edges held for n cycles, in or out of the window
    task automatic edges(input int n, input logic inWin);
        @(posedge ref_clk);
        dividedVcoEdge <= 1'b1;
        edgeInWindow <= inWin;
        repeat (n) @(posedge ref_clk);
        dividedVcoEdge <= 1'b0;
        cyc(4);
    endtask
    task automatic tick();
        @(posedge ref_clk);
        pfdTick <= 1'b1;
        @(posedge ref_clk);
        pfdTick <= 1'b0;
        cyc(3);
    endtask
    task automatic tally_and_finish();
        if (nErrors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // Hang guard at 1 ms, some 1.7 times the expected run
    initial begin
        #1ms;
        nErrors++;
        tally_and_finish();
    end
    initial begin
        seed = 22;
        {rst, chipEnablePin} = 2'b11;
        {pfdTick, dividedVcoEdge, edgeInWindow, phaseErrorLarge} = 4'h0;
        repeat (8) @(posedge ref_clk);
        rst <= 1'b0;
        cyc(6);
        for (int a = 0; a < 9; a++) begin
            rd(a[4:0], d);
            `CHK("default", dflt(a), d)
        end
        // Random words, first pass at the field maxima, integer divider at 524284
        for (int i = 0; i < 4; i++) begin
            d = (i == 0) ? 24'hffffff : 24'($random(seed));
            v = (i == 0) ? 524284 : 20 + (d % 524265);
            host.frame(PSC_ADDR_REFDIV, d);
            host.frame(PSC_ADDR_INTDIV, v[23:0]);
            host.frame(PSC_ADDR_FRACDIV, d);
            host.frame(PSC_ADDR_RSVD5, d);
            `CHK("refdiv", d[13:0], referenceDivider)
            `CHK("intdiv", v[18:0], integerDivider)
            `CHK("fracdiv", d, fractionalDivider)
            rd(PSC_ADDR_RSVD5, w);
            `CHK("reserved", d, w)
        end
        host.frame(5'h1b, 24'h000abc);
        `CHK("unmapped", d[13:0], referenceDivider)
        // Power source: pin, register, keep-on bits
        @(posedge ref_clk) chipEnablePin <= 1'b0;
        cyc(6);
        `CHK("pin off", 1'b0, chipEnabled)
        host.frame(PSC_ADDR_POWER, 24'h000002);
        `CHK("reg on", 1'b1, chipEnabled)
        host.frame(PSC_ADDR_POWER, 24'h0000fc);
        `CHK("keep on", 6'h3f, keepOnActive)
        `CHK("reg off", 1'b0, chipEnabled)
        host.frame(PSC_ADDR_POWER, 24'h000003);
        @(posedge ref_clk) chipEnablePin <= 1'b1;
        cyc(6);
        `CHK("pin on", 1'b1, chipEnabled)
        for (int o = 0; o < 4; o++) begin
            w = {PSC_RST_SDM[23:12], o[0], 2'h3, 1'b1, o[0], 1'b0, o[1], 1'b0, o[1:0], 2'h2};
            host.frame(PSC_ADDR_SDM, w);
            `CHK("order", o[1:0], sigmaDeltaOrder)
            `CHK("bypass", ~o[0], useModulatorOutput)
            `CHK("sdm on", o[0], sigmaDeltaEnable)
            `CHK("exact", o[1], exactFrequencyMode)
        end
        seeds = 0;
        host.frame(PSC_ADDR_FRACDIV, 24'h123456);
        host.frame(PSC_ADDR_SDM, PSC_RST_SDM ^ 24'h000100);
        host.frame(PSC_ADDR_FRACDIV, 24'h654321);
        `CHK("seeds", 1, seeds)
        // Synchronous load waits for the detector tick
        host.frame(PSC_ADDR_SDM, PSC_RST_SDM | 24'h000010);
        host.frame(PSC_ADDR_INTDIV, 24'h0003e8);
        `CHK("held", v[18:0], integerDivider)
        tick();
        `CHK("synced", 19'h003e8, integerDivider)
        tick();
        host.frame(PSC_ADDR_SDM, PSC_RST_SDM);
        trains = 0;
        host.frame(PSC_ADDR_LOCK, PSC_RST_LOCK | 24'h100000);
        host.frame(PSC_ADDR_LOCK, PSC_RST_LOCK | 24'h100000);
        `CHK("trains", 1, trains)
        edges(8, 1'b1);
        `CHK("lock off", 1'b0, lockDetected)
        for (int c = 0; c < 7; c++) begin
            host.frame(PSC_ADDR_LOCK, (PSC_RST_LOCK & 24'hfffff8) | 24'h000800 | c[23:0]);
            edges(cnt[c] - 1, 1'b1);
            `CHK("early", 1'b0, lockDetected)
            edges(1, 1'b1);
            `CHK("lock", 1'b1, lockDetected)
            `CHK("pin", 1'b1, lockOrReadbackPin)
            edges(1, 1'b0);
            `CHK("lost", 1'b0, lockDetected)
        end
        for (int g = 0; g < 2; g++) begin
            host.frame(PSC_ADDR_LOCK, g == 0 ? PSC_RST_LOCK | 24'h008000 : PSC_RST_LOCK);
            @(posedge ref_clk) phaseErrorLarge <= 1'b1;
            @(posedge ref_clk) phaseErrorLarge <= 1'b0;
            #1 `CHK("boost", g == 0, cycleSlipBoost)
        end
        host.frame(PSC_ADDR_ANALOG, PSC_RST_ANALOG | 24'h600000);
        `CHK("low gain", 1'b1, refBufferLowGain)
        `CHK("level", 1'b1, pinLevelHigh)
        host.frame(PSC_ADDR_ID_PTR, 24'h000020);
        `CHK("soft refdiv", 14'h0001, referenceDivider)
        `CHK("soft level", 1'b0, pinLevelHigh)
        rd(PSC_ADDR_RSVD5, w);
        `CHK("soft word", 24'h000000, w)
        tally_and_finish();
    end
endmodule
`default_nettype wire
